// *** rtl/rsq_pkg.sv ***
`default_nettype none
package rsq_pkg;

   // CPU clock
   localparam int CPU_PERIOD_NS = 8;

   // Pin-group release figures, in CPU periods (P) or memory periods (E)
   localparam int Z_MIN_P     = 2;
   localparam int Z_MAX_P     = 8;
   localparam int LOW_MAX_P   = 11;
   localparam int EXTERNAL_MEMORY_PORT_MIN_E  = 16;
   localparam int EXTERNAL_MEMORY_PORT_MAX_P  = 8;
   localparam int EXTERNAL_MEMORY_PORT_MAX_E  = 20;
   localparam int ECKI_MIN_E  = 2;

   // Chosen release points, counted from the internal release
   localparam int CNT_W       = 4;
   localparam int ECNT_W      = 5;
   localparam logic [CNT_W-1:0]  Z_ON_CNT    = CNT_W'(Z_MIN_P);
   localparam logic [CNT_W-1:0]  LOW_ON_CNT  = 4'h5;
   localparam logic [ECNT_W-1:0] EXTERNAL_MEMORY_PORT_ON_CNT = ECNT_W'(EXTERNAL_MEMORY_PORT_MIN_E);
   localparam logic [ECNT_W-1:0] ECKI_ON_CNT = ECNT_W'(ECKI_MIN_E);

   // Synchronised pin vector layout
   localparam int PIN_HWRST   = 0;
   localparam int PIN_HOST    = 1;
   localparam int PIN_EMU     = 2;
   localparam int PIN_PCIRST  = 3;
   localparam int PIN_PCIEN   = 4;
   localparam int PIN_SP2     = 5;
   localparam int PIN_HOLD    = 6;
   localparam int PIN_STRAP   = 7;
   localparam int STRAP_W     = 7;
   localparam int PIN_W       = PIN_STRAP + STRAP_W;

   // Register word indices (byte address = 4 x index)
   localparam logic [1:0] REG_CTRL    = 2'h0;
   localparam logic [1:0] REG_STATUS  = 2'h1;
   localparam logic [1:0] REG_BOOT    = 2'h2;
   localparam logic [1:0] REG_WARMCNT = 2'h3;

   localparam int CTRL_RESTART  = 0;

   localparam int ST_HWRST    = 0;
   localparam int ST_CORERST  = 1;
   localparam int ST_ZVALID   = 2;
   localparam int ST_LOWVALID = 3;
   localparam int ST_EMIFVAL  = 4;
   localparam int ST_ECKSYNC  = 5;
   localparam int ST_PCIREADY = 6;
   localparam int ST_HOLDHIGH = 7;
   localparam int ST_EELOW    = 8;

   localparam int WARMCNT_W   = 8;

   typedef enum logic [1:0] {SEQ_HOLD, SEQ_RAMP, SEQ_RUN} rsq_seq_t;
   typedef enum logic {PCI_HELD, PCI_READY} rsq_pci_t;

endpackage
`default_nettype wire

// *** rtl/rsq_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsq_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstAsync_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } rsq_sync_t;

   rsq_sync_t q;
   rsq_sync_t d;

   // First stage feeds only the second one
   always_comb begin
      d        = q;
      d.stage1 = din;
      d.stage2 = q.stage1;
   end

   always_ff @(posedge clk or negedge rstAsync_n) begin
      if (!rstAsync_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.stage2;
endmodule
`default_nettype wire

// *** rtl/rsq_reset_seq.sv ***
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module rsq_reset_seq
   import rsq_pkg::*;
#(
   parameter int EDIV      = 4,
   parameter int WARM_HOLD = 16
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               hwReset_n,
   input  wire logic               hostSoftRestart,
   input  wire logic               emuReset,
   input  wire logic               pciBusResetIn_n,
   input  wire logic               pciSelectStrap,
   input  wire logic               serialPort2SelectStrap,
   input  wire logic [3:0]         extMemAddressStrap,
   input  wire logic               byteOrderStrap,
   input  wire logic               pciEepromAutoinitStrap,
   input  wire logic               hostDataBit5Strap,
   input  wire logic               extBusHoldIn,
   input  wire logic [1:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   output logic                    coreReset_n,
   output logic                    pciReady,
   output logic                    zGroupOe,
   output logic                    lowGroupValid,
   output logic                    eepromSerialChipSelectOe,
   output logic                    eepromSerialClkOe,
   output logic                    eepromSerialDataOe,
   output logic                    emifZGroupOe,
   output logic                    extBusHoldAckValid,
   output logic                    extBusRequestValid,
   output logic                    extMemClockOut1,
   output logic                    extMemClockOut1Oe,
   output logic                    extMemClockSynced,
   output logic      [STRAP_W-1:0] bootConfig
);
   localparam int DIV_W  = (EDIV > 1) ? $clog2(EDIV) : 1;
   localparam int HOLD_W = $clog2(WARM_HOLD + 1);
   localparam int A_EXTERNAL_MEMORY_PORT_MIN = EXTERNAL_MEMORY_PORT_MIN_E * EDIV;
   localparam int A_EXTERNAL_MEMORY_PORT_MAX = EXTERNAL_MEMORY_PORT_MAX_P + EXTERNAL_MEMORY_PORT_MAX_E * EDIV;
   localparam int A_ECKI_MIN = ECKI_MIN_E * EDIV;
   localparam int REL_W  = $clog2(A_EXTERNAL_MEMORY_PORT_MAX + 1);
   localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(EDIV - 1);
   localparam logic [DIV_W-1:0]  DIV_HALF  = DIV_W'(EDIV / 2);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(WARM_HOLD);
   localparam logic [REL_W-1:0]  REL_MAX   = REL_W'(A_EXTERNAL_MEMORY_PORT_MAX);

   typedef struct packed {
      rsq_seq_t               seq;
      logic [CNT_W-1:0]       cpuCnt;
      logic [ECNT_W-1:0]      eCnt;
      logic [DIV_W-1:0]       eDiv;
      logic                   eClk;
      logic [HOLD_W-1:0]      warmCnt;
      logic [STRAP_W-1:0]     straps;
      logic                   hwPrev;
      logic                   hostPrev;
      logic                   emuPrev;
      rsq_pci_t               pci;
      logic                   waitReq;
      logic [31:0]            rdata;
      logic [WARMCNT_W-1:0]   warmTotal;
      logic                   coreRstN;
      logic                   zOe;
      logic                   lowV;
      logic                   csOe;
      logic                   sclkOe;
      logic                   sdOe;
      logic                   emifOe;
      logic                   holdV;
      logic                   reqV;
      logic                   clkOut;
      logic                   clkOe;
      logic                   synced;
      logic [REL_W-1:0]       relCyc;
   } rsq_state_t;

   rsq_state_t       q;
   rsq_state_t       d;
   logic             sysRst_n;
   logic [PIN_W-1:0] pinRaw;
   logic [PIN_W-1:0] pinS;
   logic             hwS;
   logic             hwRise;
   logic             hostRise;
   logic             emuRise;
   logic             swRestart;
   logic             warmReq;
   logic             holdReq;
   logic             eTick;
   logic             eeLow;
   logic             relStart;
   logic             running;

   // Logic reset: asserted at once, released two edges later
   rsq_sync #(.W(1)) uRstSync (
      .clk        (clk),
      .rstAsync_n (rst_n),
      .din        (1'b1),
      .dout       (sysRst_n)
   );

   always_comb begin
      pinRaw = '0;
      pinRaw[PIN_HWRST]  = hwReset_n;
      pinRaw[PIN_HOST]   = hostSoftRestart;
      pinRaw[PIN_EMU]    = emuReset;
      pinRaw[PIN_PCIRST] = pciBusResetIn_n;
      pinRaw[PIN_PCIEN]  = pciSelectStrap;
      pinRaw[PIN_SP2]    = serialPort2SelectStrap;
      pinRaw[PIN_HOLD]   = extBusHoldIn;
      pinRaw[PIN_STRAP +: STRAP_W] = {extMemAddressStrap, byteOrderStrap,
                                      pciEepromAutoinitStrap,
                                      hostDataBit5Strap};
   end

   // All pins, hardware reset included, cross in before use
   rsq_sync #(.W(PIN_W)) uPinSync (
      .clk        (clk),
      .rstAsync_n (sysRst_n),
      .din        (pinRaw),
      .dout       (pinS)
   );

   always_comb begin
      d        = q;
      hwS      = pinS[PIN_HWRST];
      hwRise   = hwS & ~q.hwPrev;
      hostRise = pinS[PIN_HOST] & ~q.hostPrev;
      emuRise  = pinS[PIN_EMU] & ~q.emuPrev;
      d.hwPrev   = hwS;
      d.hostPrev = pinS[PIN_HOST];
      d.emuPrev  = pinS[PIN_EMU];
      eeLow    = pinS[PIN_PCIEN] & ~pinS[PIN_SP2];

      // Register bus: one idle-high waitrequest, low for one answer cycle
      swRestart = avs_write && !q.waitReq && (avs_address == REG_CTRL) &&
                  avs_byteenable[0] && avs_writedata[CTRL_RESTART];
      d.waitReq = 1'b1;
      if ((avs_read || avs_write) && q.waitReq) begin
         d.waitReq = 1'b0;
         if (avs_read) begin
            d.rdata = '0;
            unique case (avs_address)
               REG_CTRL: d.rdata = '0;
               REG_STATUS: begin
                  d.rdata[ST_HWRST]    = ~hwS;
                  d.rdata[ST_CORERST]  = ~q.coreRstN;
                  d.rdata[ST_ZVALID]   = q.zOe;
                  d.rdata[ST_LOWVALID] = q.lowV;
                  d.rdata[ST_EMIFVAL]  = q.emifOe;
                  d.rdata[ST_ECKSYNC]  = q.synced;
                  d.rdata[ST_PCIREADY] = (q.pci == PCI_READY);
                  d.rdata[ST_HOLDHIGH] = pinS[PIN_HOLD];
                  d.rdata[ST_EELOW]    = eeLow;
               end
               REG_BOOT:    d.rdata[STRAP_W-1:0]   = q.straps;
               REG_WARMCNT: d.rdata[WARMCNT_W-1:0] = q.warmTotal;
            endcase
         end
      end

      // PCI state: only its own bus reset touches it
      if (!pinS[PIN_PCIRST]) begin
         d.pci = PCI_HELD;
      end else if (q.pci == PCI_HELD) begin
         d.pci = PCI_READY;
      end

      // Host restart needs PCI up; emulation and software paths do not
      warmReq = (hostRise && pinS[PIN_PCIEN] && (q.pci == PCI_READY))
                || emuRise || swRestart;
      if (warmReq && (q.warmTotal != '1)) begin
         d.warmTotal = q.warmTotal + 1'b1;
      end
      if (warmReq) begin
         d.warmCnt = HOLD_LOAD;
      end else if (q.warmCnt != '0) begin
         d.warmCnt = q.warmCnt - 1'b1;
      end

      // Straps follow only the hardware reset edge, never a warm restart
      if (hwRise) begin
         d.straps = pinS[PIN_STRAP +: STRAP_W];
      end

      holdReq  = !hwS || warmReq || (q.warmCnt != '0);
      relStart = (q.seq == SEQ_RAMP) && (q.cpuCnt == '0);
      eTick    = (q.eDiv == DIV_LAST);

      // Memory clock restarts in phase with the release
      unique case (q.seq)
         SEQ_HOLD: begin
            d.seq    = SEQ_RAMP;
            d.cpuCnt = '0;
            d.eCnt   = '0;
            d.eDiv   = '0;
            d.relCyc = '0;
         end
         SEQ_RAMP, SEQ_RUN: begin
            d.eDiv = eTick ? '0 : q.eDiv + 1'b1;
            if (q.cpuCnt != '1) begin
               d.cpuCnt = q.cpuCnt + 1'b1;
            end
            if (eTick && (q.eCnt != '1)) begin
               d.eCnt = q.eCnt + 1'b1;
            end
            if (q.relCyc != REL_MAX) begin
               d.relCyc = q.relCyc + 1'b1;
            end
            if (q.eCnt >= EXTERNAL_MEMORY_PORT_ON_CNT) begin
               d.seq = SEQ_RUN;
            end
         end
      endcase
      if (holdReq) begin
         d.seq    = SEQ_HOLD;
         d.relCyc = '0;
      end
      d.eClk = (q.eDiv < DIV_HALF);

      running      = !holdReq && (q.seq != SEQ_HOLD);
      d.coreRstN   = !holdReq && (q.seq == SEQ_RUN);
      d.zOe        = running && (q.cpuCnt >= Z_ON_CNT);
      d.lowV       = running && (q.cpuCnt >= LOW_ON_CNT);
      // Serial clock and data share one enable since they share a group
      d.csOe       = eeLow ? d.lowV : d.zOe;
      d.sclkOe     = eeLow ? d.lowV : d.zOe;
      d.sdOe       = eeLow ? d.lowV : d.zOe;
      d.emifOe     = running && (q.eCnt >= EXTERNAL_MEMORY_PORT_ON_CNT);
      // Hold-ack timing is the same in either group, so one release point
      d.holdV      = d.emifOe;
      d.reqV       = d.emifOe;
      d.synced     = running && (q.eCnt >= ECKI_ON_CNT);
      d.clkOe      = d.emifOe;
      d.clkOut     = d.clkOe && q.eClk;
   end

   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         q         <= '0;
         q.seq     <= SEQ_HOLD;
         q.pci     <= PCI_HELD;
         q.waitReq <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata             = q.rdata;
   assign avs_waitrequest          = q.waitReq;
   assign coreReset_n              = q.coreRstN;
   assign pciReady                 = (q.pci == PCI_READY);
   assign zGroupOe                 = q.zOe;
   assign lowGroupValid            = q.lowV;
   assign eepromSerialChipSelectOe = q.csOe;
   assign eepromSerialClkOe        = q.sclkOe;
   assign eepromSerialDataOe       = q.sdOe;
   assign emifZGroupOe             = q.emifOe;
   assign extBusHoldAckValid       = q.holdV;
   assign extBusRequestValid       = q.reqV;
   assign extMemClockOut1          = q.clkOut;
   assign extMemClockOut1Oe        = q.clkOe;
   assign extMemClockSynced        = q.synced;
   assign bootConfig               = q.straps;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!sysRst_n);

   a_straps_hw_only: assert property (
      !$stable(q.straps) |-> $past(hwRise))
      else $error("boot straps changed without hardware reset edge");
   a_z_float_hold: assert property (
      (q.seq == SEQ_HOLD) |=> !q.zOe)
      else $error("Z group driven during reset");
   a_z_min_delay: assert property (
      relStart |-> !q.zOe [*2])
      else $error("Z group driven earlier than 2 CPU periods");
   a_z_max_delay: assert property (
      relStart ##1 (q.seq != SEQ_HOLD) [*7] |-> q.zOe)
      else $error("Z group not driven within 8 CPU periods");
   a_low_valid: assert property (
      relStart ##1 (q.seq != SEQ_HOLD) [*6] |-> q.lowV && !$past(q.lowV, 6))
      else $error("low group release timing wrong");
   a_eeprom_group: assert property (
      q.csOe == ($past(eeLow) ? q.lowV : q.zOe))
      else $error("EEPROM chip select in wrong pin group");
   a_external_memory_port_min: assert property (
      $rose(q.emifOe) |-> (q.relCyc >= A_EXTERNAL_MEMORY_PORT_MIN))
      else $error("memory Z group driven before 16 memory periods");
   a_external_memory_port_max: assert property (
      (q.relCyc == REL_MAX) |-> q.emifOe)
      else $error("memory Z group late");
   a_group_valid: assert property (
      (q.relCyc == REL_MAX) |-> (q.holdV && q.reqV))
      else $error("hold ack or bus request not valid in time");
   a_eck_sync: assert property (
      $rose(q.synced) |-> (q.relCyc >= A_ECKI_MIN) && (q.relCyc < REL_MAX))
      else $error("memory clock resync outside its window");
   a_clkout_valid: assert property (
      (q.seq == SEQ_HOLD) |=> !q.clkOe && !q.clkOut)
      else $error("memory clock output driven during reset");
   a_pci_kept: assert property (
      (q.pci == PCI_READY) && pinS[PIN_PCIRST] |=> (q.pci == PCI_READY))
      else $error("PCI state lost without PCI bus reset");
   a_pci_reset: assert property (
      !pinS[PIN_PCIRST] && !hwRise
      |=> (q.pci == PCI_HELD) && $stable(q.straps))
      else $error("PCI bus reset misbehaved");
   a_warm_restart: assert property (
      warmReq |=> (!q.coreRstN && (q.seq == SEQ_HOLD)) [*2])
      else $error("warm restart did not hold the core in reset");
endmodule
`default_nettype wire

// *** tb/rsq_board_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsq_board_model #(
   parameter int HW_HOLD = 31250
) (
   input  wire logic       clk,
   output logic            hwReset_n,
   output logic            pciBusResetIn_n,
   output logic            pciSelectStrap,
   output logic            hostSoftRestart,
   output logic            emuReset,
   output logic      [6:0] straps
);
   initial begin
      hwReset_n       = 1'b0;
      pciBusResetIn_n = 1'b1;
      pciSelectStrap  = 1'b1;
      hostSoftRestart = 1'b0;
      emuReset        = 1'b0;
      straps          = 7'h00;
   end

   task automatic hwLow();
      @(posedge clk);
      hwReset_n <= 1'b0;
   endtask

   // The PCI clock is taken as free running long before any release
   task automatic hwRelease(input logic [6:0] s);
      repeat (HW_HOLD) @(posedge clk);
      straps <= s;
      repeat (20) @(posedge clk);
      hwReset_n <= 1'b1;
      fork
         begin
            // Flip after the hold time so that late capture shows up
            repeat (4) @(posedge clk);
            straps <= ~s;
         end
      join_none
   endtask

   task automatic pulse(input logic emu);
      @(posedge clk);
      if (emu) emuReset <= 1'b1;
      else hostSoftRestart <= pciSelectStrap;
      repeat (4) @(posedge clk);
      emuReset        <= 1'b0;
      hostSoftRestart <= 1'b0;
   endtask

   task automatic pciReset(input logic lvl);
      @(posedge clk);
      pciBusResetIn_n <= lvl;
   endtask
endmodule
`default_nettype wire

// *** tb/rsq_reset_seq_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module rsq_reset_seq_tb_top
   import rsq_pkg::*;
;
   localparam int EDIV      = 4;
   localparam int WARM_HOLD = 16;

   logic             clk, rst_n, sp2, holdIn, avRead, avWrite;
   logic      [1:0]  avAddr;
   logic      [3:0]  avBe;
   logic      [31:0] avWdata;
   logic      [6:0]  bootExp;
   int               badCount, numChecks;
   wire logic        hwRst_n, pciRst_n, pciSel, hostRst, emuRst;
   wire logic        pciReady, avWait;
   wire logic [31:0] avRdata;
   wire logic [6:0]  straps, bootCfg;
   // 0 z, 1 low, 2 external_memory_port, 3 sync, 4 clkOe, 5 hold, 6 req, 7-9 eeprom, 10 core
   wire logic [11:0] grp;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   rsq_board_model #(.HW_HOLD(31250)) u_brd (
      .clk(clk), .hwReset_n(hwRst_n), .pciBusResetIn_n(pciRst_n),
      .pciSelectStrap(pciSel), .hostSoftRestart(hostRst),
      .emuReset(emuRst), .straps(straps)
   );

   rsq_reset_seq #(.EDIV(EDIV), .WARM_HOLD(WARM_HOLD)) u_dut (
      .clk(clk), .rst_n(rst_n), .hwReset_n(hwRst_n),
      .hostSoftRestart(hostRst), .emuReset(emuRst),
      .pciBusResetIn_n(pciRst_n), .pciSelectStrap(pciSel),
      .serialPort2SelectStrap(sp2), .extMemAddressStrap(straps[6:3]),
      .byteOrderStrap(straps[2]), .pciEepromAutoinitStrap(straps[1]),
      .hostDataBit5Strap(straps[0]), .extBusHoldIn(holdIn),
      .avs_address(avAddr), .avs_read(avRead), .avs_write(avWrite),
      .avs_writedata(avWdata), .avs_byteenable(avBe),
      .avs_readdata(avRdata), .avs_waitrequest(avWait),
      .coreReset_n(grp[10]), .pciReady(pciReady), .zGroupOe(grp[0]),
      .lowGroupValid(grp[1]), .eepromSerialChipSelectOe(grp[7]),
      .eepromSerialClkOe(grp[8]), .eepromSerialDataOe(grp[9]),
      .emifZGroupOe(grp[2]), .extBusHoldAckValid(grp[5]),
      .extBusRequestValid(grp[6]), .extMemClockOut1(grp[11]),
      .extMemClockOut1Oe(grp[4]), .extMemClockSynced(grp[3]),
      .bootConfig(bootCfg)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      numChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD t=%0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic wrapUp();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic wr, input logic [1:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      avAddr  <= a;
      avWdata <= d;
      avRead  <= ~wr;
      avWrite <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avWait !== 1'b0 && n < 50);
      q = avRdata;
      avRead  <= 1'b0;
      avWrite <= 1'b0;
      if (n >= 50) begin
         badCount++;
         wrapUp();
      end
   endtask

   // First rise after a low of each group; absolute bounds only from a pin
   // edge, where the release sits three edges after the pin
   task automatic measure(input logic eeLow, input logic warm);
      int        t[12];
      bit [11:0] lowSeen;
      t = '{default: 0};
      lowSeen = '0;
      for (int n = 1; n <= 160; n++) begin
         @(posedge clk);
         #1;
         for (int k = 0; k < 12; k++)
            if (grp[k] === 1'b0) lowSeen[k] = 1'b1;
            else if (grp[k] === 1'b1 && lowSeen[k] && t[k] == 0) t[k] = n;
      end
      if (!warm) begin
         chk(32'(t[0] inside {[5:11]}), 32'h1, "z group");
         chk(32'(t[1] inside {[1:14]}), 32'h1, "low group");
         chk(32'(t[2] inside {[67:91]}), 32'h1, "external_memory_port z");
         chk(32'(t[3] inside {[11:91]}), 32'h1, "clock sync");
         chk(32'(t[4] <= 91 && t[5] <= 91 && t[6] <= 91), 32'h1,
             "external_memory_port groups");
      end
      chk(32'(t[2] - t[0] inside {[56:86]}), 32'h1, "external_memory_port gap");
      chk(32'(t[1] - t[0] <= 9), 32'h1, "low gap");
      for (int k = 1; k < 12; k++)
         chk(32'(t[k] > 0), 32'h1, "driven");
      for (int k = 7; k < 10; k++)
         chk(32'(t[k]), 32'(eeLow ? t[1] : t[0]), "eeprom");
   endtask

   task automatic tHw(input logic [6:0] s, input logic sp, input logic hd);
      logic [31:0] q;
      @(posedge clk);
      sp2    <= sp;
      holdIn <= hd;
      u_brd.hwLow();
      repeat (6) @(posedge clk);
      #1;
      chk({20'h0, grp}, 32'h0, "in reset");
      xfer(1'b0, REG_STATUS, 32'h0, q);
      chk(q, {23'h0, ~sp, hd, 7'h43}, "status low");
      u_brd.hwRelease(s);
      measure(~sp, 1'b0);
      bootExp = s;
      chk({25'h0, bootCfg}, {25'h0, s}, "capture");
      xfer(1'b0, REG_STATUS, 32'h0, q);
      chk(q, {23'h0, ~sp, hd, 7'h7C}, "status run");
      $display("hw reset test done");
   endtask

   task automatic tWarm(input logic [1:0] kind);
      logic [31:0] c0;
      logic [31:0] q;
      xfer(1'b0, REG_WARMCNT, 32'h0, c0);
      if (kind == 2'h2) xfer(1'b1, REG_CTRL, 32'h1, q);
      else u_brd.pulse(kind[0]);
      measure(pciSel & ~sp2, 1'b1);
      chk({25'h0, bootCfg}, {25'h0, bootExp}, "relatch");
      xfer(1'b0, REG_WARMCNT, 32'h0, q);
      chk(q, c0 + 32'h1, "count");
      $display("warm restart test %0d done", kind);
   endtask

   task automatic tPci();
      logic [31:0] c0;
      logic [31:0] q;
      xfer(1'b0, REG_WARMCNT, 32'h0, c0);
      u_brd.pciReset(1'b0);
      repeat (6) @(posedge clk);
      u_brd.pulse(1'b0);
      // Restart bit without its byte lane must be ignored
      avBe <= 4'hE;
      xfer(1'b1, REG_CTRL, 32'h1, q);
      avBe <= 4'hF;
      repeat (20) @(posedge clk);
      #1;
      chk({31'h0, pciReady}, 32'h0, "pci held");
      chk({21'h0, grp[10:0]}, 32'h7FF, "core kept");
      xfer(1'b0, REG_WARMCNT, 32'h0, q);
      chk(q, c0, "refused");
      u_brd.pciReset(1'b1);
      repeat (6) @(posedge clk);
      #1;
      chk({31'h0, pciReady}, 32'h1, "pci back");
      $display("pci reset test done");
   endtask

   initial begin
      rst_n     = 1'b0;
      sp2       = 1'b0;
      holdIn    = 1'b0;
      avAddr    = 2'h0;
      avRead    = 1'b0;
      avWrite   = 1'b0;
      avWdata   = 32'h0;
      avBe      = 4'hF;
      bootExp   = 7'h00;
      badCount  = 0;
      numChecks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      tHw(7'h5A, 1'b0, 1'b0);
      tWarm(2'h0);
      tWarm(2'h1);
      tWarm(2'h2);
      tPci();
      tHw(7'h25, 1'b1, 1'b1);
      wrapUp();
   end
endmodule
`default_nettype wire
